// ==== logic/zcd_defines.vh ====
/*
 * register map, field positions and reset values of the zero-cross logic.
 * assumes an apb slave with 32-bit data, one aligned word per register.
 */
`ifndef ZCD_DEFINES_VH
`define ZCD_DEFINES_VH

`define ZCD_ADDR_W          8
`define ZCD_OFF_CTRL        8'h00
`define ZCD_OFF_STATUS      8'h04
`define ZCD_OFF_MASK        8'h08
`define ZCD_OFF_SYS         8'h0C

`define ZCD_BIT_SW_EN       7
`define ZCD_BIT_OUT         5
`define ZCD_BIT_INV         4
`define ZCD_BIT_RISE_EN     1
`define ZCD_BIT_FALL_EN     0
`define ZCD_CTRL_WMASK      8'h93
`define ZCD_CTRL_RST        8'h00

`define ZCD_BIT_FLAG        0
`define ZCD_BIT_IE          0
`define ZCD_BIT_PMD         0
`define ZCD_BIT_PERIPHERAL_IRQ_ENABLE        1
`define ZCD_BIT_GIE         2
`define ZCD_BIT_PRIO        3
`define ZCD_BIT_PRIO_EN     4
`define ZCD_SYS_RST         5'h00

`endif

// ==== logic/zcd_logic.v ====
/*
 * zero-cross detector control: enable, pin ownership, polarity, edge
 * interrupts, interrupt flag, apb register slave.
 * assumes the analog front end reports sink-active on sense_sink, async.
 */
// Design decisions made here: the register offsets and register access over APB.
// What this block does
// - current action and interrupts keep running in sleep
// - fuse clear: detector always on once the fuse is caught after reset release
// - fuse set: software enable bit 7 enables
// - enabled forces pin; else pps/direction own it
// - output bit 5: sinking reads one, inverted by polarity
// - polarity bit 4 inverts the logic output
// - rise enable bit 1 sets flag on rising
// - fall enable bit 0 sets flag on falling
// - module disable bit off, unless fuse forces on
// - bits 6, 3, 2 read zero, ignore writes
// - flag cleared by software; new edge wins
// - polarity change counts as output transition
// - request needs flag, ie, peripheral_irq_enable, gie; priority selects
`timescale 1ns/1ns
`include "zcd_defines.vh"

module zcd_logic (
    input  wire                   core_clk,
    input  wire                   rstn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [31:0]            paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire                   fuse_disable,
    input  wire                   sense_sink,
    input  wire                   pps_pin_oe,
    input  wire                   pps_pin_out,
    output reg                    detector_active,
    output reg                    pin_oe,
    output reg                    pin_out,
    output reg                    logic_out,
    output reg                    irq,
    output reg                    irq_high,
    output reg                    irq_low
);

    reg  [7:0]  ctrl_reg;
    reg         flag_reg;
    reg         ie_reg;
    reg  [4:0]  sys_reg;
    reg         fuse_reg;
    reg         fuse_seen_reg;
    reg  [2:0]  sync_reg;
    reg         sink_reg;
    reg         out_prev_reg;
    reg         ena_prev_reg;
    reg         inv_prev_reg;

    wire        wr_acc;
    wire        rd_acc;
    wire        addr_ok;
    wire        enabled;
    wire        out_now;
    wire        rise_ev;
    wire        fall_ev;
    wire        pol_chg;
    wire        edge_set;
    wire        flag_clr;
    wire        req;
    wire [7:0]  ctrl_rd;

    assign wr_acc  = psel & penable & pwrite;
    assign rd_acc  = psel & penable & ~pwrite;
    assign addr_ok = (paddr[7:0] == `ZCD_OFF_CTRL) | (paddr[7:0] == `ZCD_OFF_STATUS) |
                     (paddr[7:0] == `ZCD_OFF_MASK) | (paddr[7:0] == `ZCD_OFF_SYS);

    // fuse strap caught once after reset release, never under reset
    // reads as off until caught, so the pin is never grabbed for one stray cycle
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fuse_reg      <= 1'b1;
            fuse_seen_reg <= 1'b0;
        end else if (!fuse_seen_reg) begin
            fuse_reg      <= fuse_disable;
            fuse_seen_reg <= 1'b1;
        end
    end

    // fuse clear wins over both software enable and module disable
    assign enabled = ~fuse_reg | (ctrl_reg[`ZCD_BIT_SW_EN] & ~sys_reg[`ZCD_BIT_PMD]);

    // three stages; second and third must agree before sink level moves
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_reg <= 3'b000;
            sink_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], sense_sink};
            if (sync_reg[1] == sync_reg[2]) begin
                sink_reg <= sync_reg[2];
            end
        end
    end

    // no clock gating for sleep: logic is always clocked, so it runs on
    assign out_now = sink_reg ^ ctrl_reg[`ZCD_BIT_INV];

    // polarity flips the output too, so it is caught by the same edge detect
    // a polarity write counts even while the detector is off
    assign pol_chg  = ctrl_reg[`ZCD_BIT_INV] ^ inv_prev_reg;
    assign rise_ev  = ((enabled & ena_prev_reg) | pol_chg) & ~out_prev_reg & out_now;
    assign fall_ev  = ((enabled & ena_prev_reg) | pol_chg) & out_prev_reg & ~out_now;
    assign edge_set = (rise_ev & ctrl_reg[`ZCD_BIT_RISE_EN]) |
                      (fall_ev & ctrl_reg[`ZCD_BIT_FALL_EN]);
    assign flag_clr = rd_acc & (paddr[7:0] == `ZCD_OFF_STATUS);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_prev_reg <= 1'b0;
            ena_prev_reg <= 1'b0;
            inv_prev_reg <= 1'b0;
        end else begin
            out_prev_reg <= out_now;
            ena_prev_reg <= enabled;
            inv_prev_reg <= ctrl_reg[`ZCD_BIT_INV];
        end
    end

    // set beats the read-clear in the same cycle
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
        end else if (edge_set) begin
            flag_reg <= 1'b1;
        end else if (flag_clr) begin
            flag_reg <= 1'b0;
        end
    end

    // register writes take effect on the access edge
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= `ZCD_CTRL_RST;
            ie_reg   <= 1'b0;
            sys_reg  <= `ZCD_SYS_RST;
        end else if (wr_acc) begin
            case (paddr[7:0])
                `ZCD_OFF_CTRL: begin
                    ctrl_reg <= pwdata[7:0] & `ZCD_CTRL_WMASK;
                end
                `ZCD_OFF_MASK: begin
                    ie_reg <= pwdata[`ZCD_BIT_IE];
                end
                `ZCD_OFF_SYS: begin
                    sys_reg <= pwdata[4:0];
                end
                default: begin
                    ie_reg <= ie_reg;
                end
            endcase
        end
    end

    // output bit is live; stored bit 5 is always zero by the write mask
    assign ctrl_rd = {ctrl_reg[7:6], out_now, ctrl_reg[4:0]};

    assign req = flag_reg & ie_reg & sys_reg[`ZCD_BIT_PERIPHERAL_IRQ_ENABLE] & sys_reg[`ZCD_BIT_GIE];

    // zero-wait slave: pready rises in the access cycle itself
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata  <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                case (paddr[7:0])
                    `ZCD_OFF_CTRL:   prdata <= {24'h000000, ctrl_rd};
                    `ZCD_OFF_STATUS: prdata <= {31'h00000000, flag_reg | edge_set};
                    `ZCD_OFF_MASK:   prdata <= {31'h00000000, ie_reg};
                    `ZCD_OFF_SYS:    prdata <= {27'h0000000, sys_reg};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // pin owned by the detector while enabled, else by pps and direction
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            detector_active <= 1'b0;
            pin_oe          <= 1'b0;
            pin_out         <= 1'b0;
            logic_out       <= 1'b0;
            irq             <= 1'b0;
            irq_high        <= 1'b0;
            irq_low         <= 1'b0;
        end else begin
            detector_active <= enabled;
            pin_oe          <= ~enabled & pps_pin_oe;
            pin_out         <= ~enabled & pps_pin_out;
            logic_out       <= out_now;
            irq             <= req;
            // without priority mode every request is high priority
            irq_high        <= req & (~sys_reg[`ZCD_BIT_PRIO_EN] | sys_reg[`ZCD_BIT_PRIO]);
            irq_low         <= req & sys_reg[`ZCD_BIT_PRIO_EN] & ~sys_reg[`ZCD_BIT_PRIO];
        end
    end

endmodule // zcd_logic

// ==== testbench/zcd_ac_src.sv ====
/* zcd_ac_src: ac source behind the series resistor.
   free running at random half periods, or held at a level. */
`timescale 1ns/1ns
module zcd_ac_src (
    input wire    run,
    input wire    lvl,
    output wire   sense_sink
);
    logic osc = 1'b0;
    // one driver: oscillator while running, else the held level
    assign sense_sink = run ? osc : lvl;
    // no relation to core_clk, so the sync sees every phase
    always begin
        #(300 + $urandom % 900);
        osc = ~osc;
    end
endmodule // zcd_ac_src

// ==== testbench/zcd_chk.sv ====
/* zcd_chk: port assertions for zcd_logic.
   assumes a bind from the bench; apb writes land with pready. */
`timescale 1ns/1ns
module zcd_chk (
    input wire        core_clk, rstn, psel, penable, pwrite, pready, fuse_disable, sense_sink,
    input wire [31:0] paddr, pwdata, prdata,
    input wire        pps_pin_oe, pps_pin_out, detector_active, pin_oe, pin_out, logic_out,
    input wire        irq, irq_high, irq_low
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    reg inv_reg; // polarity as last written
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            inv_reg <= 1'b0;
        else if (pready && pwrite && paddr[7:0] == 8'h00)
            inv_reg <= pwdata[4];
    end
    chk_pin_forced: assert property (detector_active |-> !pin_oe && !pin_out)
        else $error("pin not held for detector");
    chk_pin_follow: assert property (!detector_active [*2] |->
        pin_oe == $past(pps_pin_oe) && pin_out == $past(pps_pin_out)) else $error("pin ignores select");
    chk_out_pol: assert property ((detector_active && $stable(sense_sink) && $stable(inv_reg)) [*6]
        |-> logic_out == (sense_sink ^ inv_reg)) else $error("logic output wrong");
    chk_ctrl_zero: assert property (pready && !pwrite && paddr[7:0] == 8'h00 |->
        (prdata & 32'hFFFFFF4C) == 32'h0) else $error("unused control bits set");
    chk_fuse_on: assert property (!fuse_disable [*4] |-> detector_active)
        else $error("fuse did not force on");
    chk_sw_enable: assert property (fuse_disable && $rose(detector_active) |->
        $past(pready, 1) || $past(pready, 2) || $past(pready, 3)) else $error("enable without write");
    chk_irq_split: assert property (irq [*2] |-> irq_high ^ irq_low)
        else $error("priority split wrong");
    chk_irq_clear: assert property ($fell(irq) |->
        $past(pready, 1) || $past(pready, 2) || $past(pready, 3)) else $error("flag cleared by itself");
    cover property ($rose(irq));
    cover property ($fell(logic_out) && detector_active);
    cover property (pready && pwrite);
endmodule // zcd_chk

// ==== testbench/zcd_logic_tb.sv ====
/* zcd_logic_tb: self-checking bench for zcd_logic over apb.
   ac source model on sense_sink; checker bound at the foot. */
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t bad value", $time); end end
module zcd_logic_tb;
    logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fuse_disable = 1;
    logic        pps_pin_oe = 0, pps_pin_out = 0, run = 0, lvl = 0, err;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [7:0]  v;
    logic [1:0]  p;
    wire  [31:0] prdata;
    wire         pready, pslverr, sense_sink, detector_active, pin_oe, pin_out, logic_out, irq, irq_high, irq_low;
    int          error_cnt = 0, n_compared = 0, k;
    zcd_logic u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fuse_disable(fuse_disable), .sense_sink(sense_sink), .pps_pin_oe(pps_pin_oe),
        .pps_pin_out(pps_pin_out), .detector_active(detector_active), .pin_oe(pin_oe), .pin_out(pin_out),
        .logic_out(logic_out), .irq(irq), .irq_high(irq_high), .irq_low(irq_low));
    zcd_ac_src u_src (.run(run), .lvl(lvl), .sense_sink(sense_sink));
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) {pps_pin_oe, pps_pin_out} <= rstn ? 2'($urandom) : 2'b00;
    function automatic logic [7:0] exp_ctrl(input logic [7:0] w); return w & 8'h93; endfunction
    function automatic logic exp_out(input logic s, input logic i); return s ^ i; endfunction
    // {high, low} for a pending request; no priority mode means high
    function automatic logic [1:0] exp_prio(input logic [1:0] q); return {~q[1] | q[0], q[1] & ~q[0]}; endfunction
    task automatic end_sim(input bit hung);
        if (hung) error_cnt++;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rst(input logic f);
        @(posedge core_clk);
        rstn <= 0;
        fuse_disable <= f;
        repeat (8) @(posedge core_clk);
        rstn <= 1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic ap(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge core_clk);
        if (i == 16) end_sim(1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic ev(input logic l, input logic x); // move source, check and clear flag
        lvl <= l;
        repeat (8) @(posedge core_clk);
        `CHK(irq, x)
        `CHK(irq_high, x)
        ap(0, 8'h04, 0);
        `CHK(rd[0], x)
    endtask
    initial begin
        rd = $urandom(99604);
        rst(1);
        ap(0, 8'h00, 0);
        `CHK(rd & 32'hFFFFFFDF, 32'h0)
        ap(0, 8'h40, 0);
        `CHK(err, 1'b1)
        for (k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'hFF : 8'($urandom);
            ap(1, 8'h00, v);
            ap(0, 8'h00, 0);
            `CHK(rd[7:0] & 8'hDF, exp_ctrl(v))
            `CHK(detector_active, v[7])
        end
        for (k = 0; k < 4; k++) begin
            lvl <= k[0];
            ap(1, 8'h00, {3'b100, k[1], 4'h0});
            repeat (8) @(posedge core_clk);
            ap(0, 8'h00, 0);
            `CHK(rd[5], exp_out(k[0], k[1]))
        end
        $display("test register and polarity done");
        ap(1, 8'h0C, 8'h06);
        ap(1, 8'h08, 8'h01);
        for (k = 0; k < 4; k++) begin
            ap(1, 8'h00, {6'h20, k[1:0]});
            lvl <= 0;
            repeat (8) @(posedge core_clk);
            ap(0, 8'h04, 0);
            ev(1, k[1]);
            ap(0, 8'h04, 0);
            `CHK(rd[0], 1'b0)
            ev(0, k[0]);
        end
        ap(1, 8'h00, 8'h93);
        repeat (8) @(posedge core_clk);
        ap(0, 8'h04, 0);
        `CHK(rd[0], 1'b1)
        ap(1, 8'h00, 8'h03);
        repeat (3) @(posedge core_clk);
        ap(0, 8'h04, 0);
        `CHK(rd[0], 1'b1)
        $display("test edge interrupts done");
        rst(0);
        `CHK(detector_active, 1'b1)
        ap(1, 8'h0C, 8'h01);
        repeat (3) @(posedge core_clk);
        `CHK(detector_active, 1'b1)
        rst(1);
        ap(1, 8'h00, 8'h80);
        ap(1, 8'h0C, 8'h01);
        repeat (3) @(posedge core_clk);
        `CHK(detector_active, 1'b0)
        p = 2'($urandom);
        ap(1, 8'h0C, {3'h0, p, 3'h6});
        ap(1, 8'h00, 8'h83);
        run <= 1;
        for (k = 0; k < 40; k++) begin
            repeat ($urandom % 50) @(posedge core_clk);
            if (irq === 1'b1) `CHK({irq_high, irq_low}, exp_prio(p))
            ap(0, 8'h04, 0);
        end
        `CHK(detector_active, 1'b1)
        $display("test random crossings done");
        end_sim(0);
    end
endmodule // zcd_logic_tb
bind zcd_logic zcd_chk u_chk (.*);
